/* File: bench/swdt_props.sv */
// Checker for the watchdog top: bus handshakes and reset pulse
`timescale 1ns/10ps
module swdt_props #(
	parameter int RST_PULSE = 16
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic SYS_RESET_N
);
	localparam int LOW_LEN = RST_PULSE - 1;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	// ==========================================
	// Assertions
	chk_pulse_len: assert property (
		$fell(SYS_RESET_N) |-> ##LOW_LEN !SYS_RESET_N ##1 SYS_RESET_N)
		else $error("system reset pulse has wrong length");
	chk_bvalid_hold: assert property (
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped early");
	chk_rvalid_hold: assert property (
		S_AXI_RVALID && !S_AXI_RREADY |=> $stable(S_AXI_RRESP) && S_AXI_RVALID)
		else $error("read response dropped or changed");
	chk_read_answer: assert property (
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	chk_write_answer: assert property (
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
		|-> ##[1:2] S_AXI_BVALID)
		else $error("write answer late");
	chk_write_block: assert property (
		S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken while response pending");
	chk_read_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read taken while answer pending");
	chk_rresp_code: assert property (
		S_AXI_RVALID |-> S_AXI_RRESP == 2'h0 || S_AXI_RRESP == 2'h2)
		else $error("illegal read response code");
	// Covers
	cov_expiry: cover property ($fell(SYS_RESET_N));
	cov_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
	cov_read_err: cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
endmodule

bind swdt_top swdt_props #(.RST_PULSE(RST_PULSE)) u_props (
	.SYS_CLK(SYS_CLK), .RST_N(RST_N),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY), .SYS_RESET_N(SYS_RESET_N));

/* File: bench/tb.sv */
// Self-checking bench for the watchdog top
`timescale 1ns/10ps
module tb;
	import swdt_pkg::*;
	// Short second keeps the run small
	localparam int SD = 10;
	localparam int RP = 8;
	logic clk = 1'h0, rst_n = 1'h0;
	logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, seed;
	logic u;
	int n, num_errors = 0, samples_checked = 0;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire awr, wr_rdy, bv, arr, rv, srst_n;
	always #2.5 clk = ~clk;
	swdt_top #(.SEC_DIV(SD), .RST_PULSE(RP)) dut (
		.SYS_CLK(clk), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .SYS_RESET_N(srst_n));
	// ==========================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int t;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		bready <= 1'h1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
			if (awr) awv <= 1'h0;
			if (wr_rdy) wv <= 1'h0;
		end while (bv !== 1'h1 && t < 50);
		bready <= 1'h0;
		check("bvalid", {31'h0, bv}, 32'h1);
		check("bresp", {30'h0, bresp}, {30'h0, RESP_OKAY});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int t;
		@(posedge clk);
		araddr <= a;
		arv <= 1'h1;
		rready <= 1'h1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
			if (arr) arv <= 1'h0;
		end while (rv !== 1'h1 && t < 50);
		rready <= 1'h0;
		check("rvalid", {31'h0, rv}, 32'h1);
		check("rdata", rdata, e);
		check("rresp", {30'h0, rresp}, {30'h0, er});
	endtask
	// Edges from now until the reset pulse, within a small slack
	task automatic expire(input int k, input logic m);
		int c, e;
		e = k * SD * (m ? SEC_PER_MIN : 1);
		c = 0;
		while (srst_n === 1'h1 && c < e + 20) begin
			@(posedge clk);
			c++;
		end
		check("expiry_time", 32'(c >= e - 2 && c <= e + 4), 32'h1);
		repeat (RP + 2) @(posedge clk);
	endtask
	task automatic quiet(input int k);
		logic ok;
		ok = 1'h1;
		repeat (k) begin
			@(posedge clk);
			if (srst_n !== 1'h1) ok = 1'h0;
		end
		check("no_reset", {31'h0, ok}, 32'h1);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ==========================================
	// Tests
	initial begin
		seed = 32'h00010A75;
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge clk);
		rd(REG_CTRL, 32'h2, RESP_OKAY);
		rd(REG_TIMEOUT, 32'h0, RESP_OKAY);
		rd(8'h14, 32'h0, RESP_SLVERR);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			n = i == 0 ? 1 : i == 1 ? 255 : i == 2 ? int'(seed[1:0]) + 1 : 1;
			u = i == 3;
			wr(REG_CTRL, {seed[31:2], 1'h1, u});
			wr(REG_TIMEOUT, 32'(n));
			expire(n, u);
			rd(REG_STATUS, 32'h2, RESP_OKAY);
		end
		$display("test expiry done");
		// Reload late in the count; an ignored reload fires early
		wr(REG_CTRL, 32'h2);
		wr(REG_TIMEOUT, 32'h3);
		rd(REG_STATUS, 32'h1, RESP_OKAY);
		repeat (17) @(posedge clk);
		wr(REG_CMD, 32'h2);
		expire(3, 1'h0);
		$display("test reload done");
		wr(REG_TIMEOUT, 32'h2);
		wr(REG_CMD, 32'h4);
		rd(REG_COUNT, 32'h2, RESP_OKAY);
		rd(REG_STATUS, 32'h0, RESP_OKAY);
		quiet(40);
		wr(REG_CMD, 32'h1);
		expire(2, 1'h0);
		wr(REG_TIMEOUT, 32'h2);
		wr(REG_TIMEOUT, 32'h0);
		quiet(40);
		$display("test start and halt done");
		// Service well inside the timeout; a lost reload trips quiet
		wr(REG_TIMEOUT, 32'h3);
		for (int i = 0; i < 4; i++) begin
			quiet(12);
			wr(REG_CMD, 32'h2);
		end
		wr(REG_CMD, 32'h4);
		quiet(40);
		$display("test periodic reload done");
		final_report();
	end
	initial begin
		#100000;
		num_errors++;
		final_report();
	end
endmodule

/* File: rtl/swdt_pkg.sv */
// Shared constants for the system watchdog timer
package swdt_pkg;
	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;
	// Register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TIMEOUT = 8'h04;
	localparam logic [7:0] REG_CMD = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_COUNT = 8'h10;
	// CTRL fields
	localparam int CTRL_UNIT_BIT = 0;
	localparam int CTRL_RSTEN_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;
	// CMD fields
	localparam int CMD_START_BIT = 0;
	localparam int CMD_RELOAD_BIT = 1;
	localparam int CMD_HALT_BIT = 2;
	// STATUS fields
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_EXP_BIT = 1;
	localparam logic [7:0] TICK_RESET = 8'h00;
	localparam logic UNIT_SEC = 1'b0;
	localparam logic UNIT_MIN = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Timing
	localparam longint CLK_HZ = 200000000;
	localparam int TICK_S = 1;
	localparam int SEC_PER_MIN = 60;
	localparam longint SEC_CYCLES = CLK_HZ * TICK_S;
	localparam int RST_PULSE_CYCLES = 16;
endpackage

/* File: rtl/swdt_prescaler.sv */
// Prescaler producing one-second and one-minute tick strobes
`timescale 1ns/10ps
module swdt_prescaler #(
	parameter int SEC_DIV = 200000000,
	parameter int MIN_DIV = 60
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	output logic sec_tick,
	output logic min_tick
);
	logic [31:0] sec_cnt_r;
	logic [7:0] min_cnt_r;
	// ==========================================
	// Second divider, restarts on clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_cnt_r <= '0;
			sec_tick <= 1'b0;
		end else if (clear) begin
			sec_cnt_r <= '0;
			sec_tick <= 1'b0;
		end else if (sec_cnt_r == 32'(SEC_DIV - 1)) begin
			sec_cnt_r <= '0;
			sec_tick <= 1'b1;
		end else begin
			sec_cnt_r <= sec_cnt_r + 32'h1;
			sec_tick <= 1'b0;
		end
	end
	// ==========================================
	// Minute divider counts second strobes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			min_cnt_r <= '0;
			min_tick <= 1'b0;
		end else if (clear) begin
			min_cnt_r <= '0;
			min_tick <= 1'b0;
		end else if (sec_cnt_r == 32'(SEC_DIV - 1)) begin
			if (min_cnt_r == 8'(MIN_DIV - 1)) begin
				min_cnt_r <= '0;
				min_tick <= 1'b1;
			end else begin
				min_cnt_r <= min_cnt_r + 8'h1;
				min_tick <= 1'b0;
			end
		end else begin
			min_tick <= 1'b0;
		end
	end
endmodule

/* File: rtl/swdt_top.sv */
// System watchdog timer with AXI4-Lite register access
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module swdt_top
	import swdt_pkg::*;
#(
	parameter int SEC_DIV = int'(SEC_CYCLES),
	parameter int RST_PULSE = RST_PULSE_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [swdt_pkg::AXI_AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [swdt_pkg::AXI_DW-1:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [swdt_pkg::AXI_AW-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [swdt_pkg::AXI_DW-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic SYS_RESET_N
);
	import swdt_pkg::*;

	// ==========================================
	// Reset release
	logic rst_s1_r, rst_n_r;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// ==========================================
	// Write channel capture, either order
	logic [AXI_AW-1:0] awaddr_r;
	logic [AXI_DW-1:0] wdata_r;
	logic [3:0] wstrb_r;
	logic aw_have_r, w_have_r;
	logic wr_do;
	assign wr_do = aw_have_r && w_have_r && !S_AXI_BVALID;

	always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			aw_have_r <= 1'b0;
			awaddr_r <= '0;
			S_AXI_AWREADY <= 1'b0;
		end else if (wr_do) begin
			aw_have_r <= 1'b0;
			S_AXI_AWREADY <= 1'b0;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_have_r <= 1'b1;
			awaddr_r <= S_AXI_AWADDR;
			S_AXI_AWREADY <= 1'b0;
		end else begin
			S_AXI_AWREADY <= !aw_have_r && !S_AXI_BVALID;
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			w_have_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
			S_AXI_WREADY <= 1'b0;
		end else if (wr_do) begin
			w_have_r <= 1'b0;
			S_AXI_WREADY <= 1'b0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_have_r <= 1'b1;
			wdata_r <= S_AXI_WDATA;
			wstrb_r <= S_AXI_WSTRB;
			S_AXI_WREADY <= 1'b0;
		end else begin
			S_AXI_WREADY <= !w_have_r && !S_AXI_BVALID;
		end
	end

	function automatic logic mapped(input logic [AXI_AW-1:0] a);
		mapped = (a == REG_CTRL) || (a == REG_TIMEOUT) ||
			(a == REG_CMD) || (a == REG_STATUS) || (a == REG_COUNT);
	endfunction

	always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else if (wr_do) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// Decoded write strobes, low byte lane carries all fields
	logic wr_lane0;
	logic wr_ctrl, wr_tmo, wr_cmd;
	assign wr_lane0 = wr_do && wstrb_r[0];
	assign wr_ctrl = wr_lane0 && (awaddr_r == REG_CTRL);
	assign wr_tmo = wr_lane0 && (awaddr_r == REG_TIMEOUT);
	assign wr_cmd = wr_lane0 && (awaddr_r == REG_CMD);

	// ==========================================
	// Configuration registers
	logic unit_r, rsten_r;
	logic [7:0] tick_r;
	always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			unit_r <= CTRL_RESET[CTRL_UNIT_BIT];
			rsten_r <= CTRL_RESET[CTRL_RSTEN_BIT];
		end else if (wr_ctrl) begin
			unit_r <= wdata_r[CTRL_UNIT_BIT];
			rsten_r <= wdata_r[CTRL_RSTEN_BIT];
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tick_r <= TICK_RESET;
		end else if (wr_tmo) begin
			tick_r <= wdata_r[7:0];
		end
	end

	// ==========================================
	// Countdown engine
	logic sec_tick, min_tick, unit_tick;
	logic run_r, exp_r;
	logic [7:0] count_r;
	logic do_start, do_reload, do_halt;

	// Commands: halt wins over start and reload
	assign do_halt = (wr_cmd && wdata_r[CMD_HALT_BIT]) ||
		(wr_tmo && wdata_r[7:0] == 8'h00);
	assign do_start = (wr_cmd && wdata_r[CMD_START_BIT]) ||
		(wr_tmo && wdata_r[7:0] != 8'h00);
	assign do_reload = wr_cmd && wdata_r[CMD_RELOAD_BIT] && run_r;

	// Restarting the prescaler keeps the first tick a full period long
	swdt_prescaler #(
		.SEC_DIV(SEC_DIV),
		.MIN_DIV(SEC_PER_MIN)
	) u_presc (
		.clk(SYS_CLK),
		.rst_n(rst_n_r),
		.clear(do_start || do_reload),
		.sec_tick(sec_tick),
		.min_tick(min_tick)
	);

	assign unit_tick = (unit_r == UNIT_MIN) ? min_tick : sec_tick;

	logic [7:0] start_val;
	// New timeout value applies at once on its own write
	assign start_val = wr_tmo ? wdata_r[7:0] : tick_r;

	always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			run_r <= 1'b0;
			count_r <= '0;
		end else if (do_halt) begin
			run_r <= 1'b0;
		end else if (do_start || do_reload) begin
			// Start with a zero timeout stays idle
			run_r <= (start_val != 8'h00);
			count_r <= start_val;
		end else if (run_r && unit_tick) begin
			count_r <= count_r - 8'h1;
			if (count_r == 8'h01) begin
				run_r <= 1'b0;
			end
		end
	end

	logic expire;
	assign expire = run_r && unit_tick && (count_r == 8'h01) &&
		!do_halt && !do_start && !do_reload;

	// Sticky expiry flag; a start in the same cycle masks expire, so the clear wins
	always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			exp_r <= 1'b0;
		end else if (expire) begin
			exp_r <= 1'b1;
		end else if (do_start) begin
			exp_r <= 1'b0;
		end
	end

	// ==========================================
	// System reset pulse
	logic [7:0] pulse_r;
	always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pulse_r <= '0;
			SYS_RESET_N <= 1'b1;
		end else if (expire && rsten_r) begin
			pulse_r <= 8'(RST_PULSE - 1);
			SYS_RESET_N <= 1'b0;
		end else if (pulse_r != 8'h00) begin
			pulse_r <= pulse_r - 8'h1;
		end else begin
			SYS_RESET_N <= 1'b1;
		end
	end

	// ==========================================
	// Read channel
	logic [AXI_DW-1:0] rd_val;
	always_comb begin
		rd_val = '0;
		unique case (S_AXI_ARADDR)
			REG_CTRL: begin
				rd_val[CTRL_UNIT_BIT] = unit_r;
				rd_val[CTRL_RSTEN_BIT] = rsten_r;
			end
			REG_TIMEOUT: rd_val[7:0] = tick_r;
			REG_STATUS: begin
				rd_val[STAT_RUN_BIT] = run_r;
				rd_val[STAT_EXP_BIT] = exp_r;
			end
			REG_COUNT: rd_val[7:0] = count_r;
			default: rd_val = '0;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_val;
			S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RVALID) begin
			if (S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end else begin
			S_AXI_ARREADY <= 1'b1;
		end
	end
endmodule
